/* design/clrs_pkg.sv */
// constants and types shared by the line readout sequencer
package clrs_pkg;

  // ----------------------------------------------------------------
  // array size
  // ----------------------------------------------------------------
  localparam int unsigned ROWS_PER_FRAME = 8;
  localparam int unsigned PIX_PER_ROW    = 16;
  localparam int unsigned ROW_W          = 12;
  localparam int unsigned PIX_W          = 12;

  // ----------------------------------------------------------------
  // pixel period, sixteen sub-pixel phases
  // ----------------------------------------------------------------
  localparam int unsigned PHASES    = 16;
  localparam int unsigned PH_W      = 4;
  localparam logic [3:0]  H1_RISE   = 4'h0;
  localparam logic [3:0]  H1_FALL   = 4'h8;
  localparam logic [3:0]  RST_RISE  = 4'h1;
  localparam logic [3:0]  RST_FALL  = 4'h3;
  localparam logic [3:0]  CLMP_RISE = 4'h4;
  localparam logic [3:0]  CLMP_FALL = 4'h6;
  localparam logic [3:0]  SMP_RISE  = 4'hb;
  localparam logic [3:0]  SMP_FALL  = 4'hd;
  localparam logic [3:0]  PIX_RISE  = 4'he;
  localparam logic [3:0]  PIX_FALL  = 4'hf;

  // ----------------------------------------------------------------
  // vertical transfer timing, fixed in clock cycles
  // ----------------------------------------------------------------
  localparam int unsigned VT_W       = 8;
  localparam logic [7:0]  V1_RISE    = 8'h04;
  localparam logic [7:0]  V1_FALL    = 8'h24;
  localparam logic [7:0]  V2_RISE    = 8'h14;
  localparam logic [7:0]  V2_FALL    = 8'h34;
  localparam logic [7:0]  VT_LINE_END = 8'h38; // one line moved
  localparam logic [7:0]  HSETTLE_END = 8'h48; // settle after last line

  // ----------------------------------------------------------------
  // state machine
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CLRS_FRAME_PREP,
    CLRS_VSHIFT,
    CLRS_HREAD,
    CLRS_TALLY
  } clrs_state_t;

endpackage

/* design/clrs_phase_gen.sv */
// horizontal and sampling pulse generator from the sub-pixel phase
`timescale 1ns/100ps
`default_nettype none
module clrs_phase_gen
  import clrs_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       run,
  input  wire logic [3:0] phase,
  input  wire logic       sense_en,
  output logic            h1_clk,
  output logic            h2_clk,
  output logic            diffusion_reset_clock,
  output logic            cds_clamp_pulse,
  output logic            cds_sample_pulse,
  output logic            grabber_pixel_strobe
);

  typedef struct packed {
    logic h1;
    logic rst_p;
    logic clmp;
    logic smp;
    logic pix;
  } clrs_pg_t;

  clrs_pg_t pg_r;
  clrs_pg_t pg_nxt;

  // ----------------------------------------------------------------
  // edge placement
  // ----------------------------------------------------------------
  // set and clear each pulse at its fixed phase; sense pulses gated
  always_comb begin
    pg_nxt = pg_r;
    if (!run) begin
      pg_nxt = '0;
    end else begin
      if (phase == H1_RISE) pg_nxt.h1 = 1'b1;
      if (phase == H1_FALL) pg_nxt.h1 = 1'b0;
      if (phase == RST_RISE && sense_en) pg_nxt.rst_p = 1'b1;
      if (phase == RST_FALL) pg_nxt.rst_p = 1'b0;
      if (phase == CLMP_RISE && sense_en) pg_nxt.clmp = 1'b1;
      if (phase == CLMP_FALL) pg_nxt.clmp = 1'b0;
      if (phase == SMP_RISE && sense_en) pg_nxt.smp = 1'b1;
      if (phase == SMP_FALL) pg_nxt.smp = 1'b0;
      if (phase == PIX_RISE && sense_en) pg_nxt.pix = 1'b1;
      if (phase == PIX_FALL) pg_nxt.pix = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      pg_r <= '0;
    end else begin
      pg_r <= pg_nxt;
    end
  end

  assign h1_clk                = pg_r.h1;
  assign h2_clk                = run & ~pg_r.h1;
  assign diffusion_reset_clock = pg_r.rst_p;
  assign cds_clamp_pulse       = pg_r.clmp;
  assign cds_sample_pulse      = pg_r.smp;
  assign grabber_pixel_strobe  = pg_r.pix;

endmodule
`default_nettype wire

/* design/clrs_vclock_gen.sv */
// vertical clock generator driven by the vertical transfer counter
`timescale 1ns/100ps
`default_nettype none
module clrs_vclock_gen
  import clrs_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic [7:0] vcount,
  input  wire logic       active,
  output logic            v1_clk,
  output logic            v2_clk
);

  typedef struct packed {
    logic v1;
    logic v2;
  } clrs_vg_t;

  clrs_vg_t vg_r;
  clrs_vg_t vg_nxt;

  // ----------------------------------------------------------------
  // fixed edges
  // ----------------------------------------------------------------
  // constant vertical edges
  always_comb begin
    vg_nxt = vg_r;
    if (!active) begin
      vg_nxt = '0;
    end else begin
      if (vcount == V1_RISE) vg_nxt.v1 = 1'b1;
      if (vcount == V1_FALL) vg_nxt.v1 = 1'b0;
      if (vcount == V2_RISE) vg_nxt.v2 = 1'b1;
      if (vcount == V2_FALL) vg_nxt.v2 = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      vg_r <= '0;
    end else begin
      vg_r <= vg_nxt;
    end
  end

  assign v1_clk = vg_r.v1;
  assign v2_clk = vg_r.v2;

endmodule
`default_nettype wire

/* design/clrs_line_readout.sv */
// line readout sequencer: vertical shift, horizontal readout, line tally
// What this block does
// - the vertical shift state clocks the vertical phases to move one row toward the horizontal register.
// - a vertical transfer counter places the vertical edges and marks the end of transfer plus settle time.
// - with binning two rows are shifted before horizontal readout begins.
// - vertical edge timing is constant and cannot be changed by any input.
// - the horizontal readout state clocks the horizontal register one pixel at a time.
// - a line transfer counter counts pixels of the row and times the end of the line sync output.
// - with binning two pixels are summed on the diffusion before it is sensed and reset.
// - with binning the diffusion reset, clamp, sample and pixel strobe are suppressed every other pixel.
// - after each row's readout the line tally state increments the row counter.
// - when all rows are read the tally state moves to the frame preparation state.
// - when rows remain the tally state returns to the vertical shift state.
// - frame preparation clears the row and pixel counters at the start of each frame.
// - reset clears all counters and returns the state machine to its initial state.
`timescale 1ns/100ps
`default_nettype none
module clrs_line_readout
  import clrs_pkg::*;
(
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic binning_select_jumper,
  input  wire logic frame_go,
  output logic      v1_clk,
  output logic      v2_clk,
  output logic      h1_clk,
  output logic      h2_clk,
  output logic      diffusion_reset_clock,
  output logic      cds_clamp_pulse,
  output logic      cds_sample_pulse,
  output logic      grabber_pixel_strobe,
  output logic      grabber_frame_sync,
  output logic      grabber_line_sync,
  output logic      frame_done,
  output logic      in_frame_prep
);

  // ----------------------------------------------------------------
  // state record
  // ----------------------------------------------------------------
  typedef struct packed {
    clrs_state_t      st;
    logic [VT_W-1:0]  vcnt;     // vertical transfer counter
    logic             vsecond;  // second row of a binned pair
    logic [PH_W-1:0]  phase;    // sub-pixel phase
    logic [PIX_W-1:0] pcnt;     // line transfer counter
    logic [ROW_W-1:0] rcnt;     // row counter
    logic             bin;      // binning latched per frame
    logic             fsync;
    logic             lsync;
    logic             done;
  } clrs_top_t;

  clrs_top_t s_r;
  clrs_top_t s_nxt;

  localparam logic [PIX_W-1:0] PIX_LAST = PIX_W'(PIX_PER_ROW - 1);
  localparam logic [ROW_W-1:0] ROW_FULL = ROW_W'(ROWS_PER_FRAME);
  localparam logic [ROW_W-1:0] ROW_PAIR = ROW_W'(ROWS_PER_FRAME / 2);
  localparam logic [PH_W-1:0]  PH_LAST  = PH_W'(PHASES - 1);

  logic sense_en;
  logic hrun;
  logic vact;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt      = s_r;
    s_nxt.done = 1'b0;
    case (s_r.st)
      CLRS_FRAME_PREP: begin
        s_nxt.vcnt    = '0;
        s_nxt.vsecond = 1'b0;
        s_nxt.phase   = '0;
        s_nxt.pcnt    = '0;
        s_nxt.rcnt    = '0;
        s_nxt.lsync   = 1'b0;
        s_nxt.fsync   = 1'b0;
        if (frame_go) begin
          s_nxt.bin   = binning_select_jumper;
          s_nxt.fsync = 1'b1;
          s_nxt.st    = CLRS_VSHIFT;
        end
      end
      CLRS_VSHIFT: begin
        s_nxt.vcnt = s_r.vcnt + 1'b1;
        if (s_r.vcnt == VT_LINE_END && s_r.bin && !s_r.vsecond) begin
          s_nxt.vcnt    = '0;
          s_nxt.vsecond = 1'b1;
        end else if (s_r.vcnt == HSETTLE_END) begin
          s_nxt.vcnt    = '0;
          s_nxt.vsecond = 1'b0;
          s_nxt.phase   = '0;
          s_nxt.pcnt    = '0;
          s_nxt.lsync   = 1'b1;
          s_nxt.st      = CLRS_HREAD;
        end
      end
      CLRS_HREAD: begin
        s_nxt.phase = s_r.phase + 1'b1;
        if (s_r.phase == PH_LAST) begin
          s_nxt.pcnt = s_r.pcnt + 1'b1;
          if (s_r.pcnt == PIX_LAST) begin
            s_nxt.pcnt  = '0;
            s_nxt.lsync = 1'b0;
            s_nxt.st    = CLRS_TALLY;
          end
        end
      end
      CLRS_TALLY: begin
        s_nxt.rcnt = s_r.rcnt + 1'b1;
        if (s_r.rcnt + 1'b1 >= (s_r.bin ? ROW_PAIR : ROW_FULL)) begin
          s_nxt.st    = CLRS_FRAME_PREP;
          s_nxt.fsync = 1'b0;
          s_nxt.done  = 1'b1;
        end else begin
          s_nxt.st = CLRS_VSHIFT;
        end
      end
      default: begin
        s_nxt.st = CLRS_FRAME_PREP;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // reset clears counters and state
  always_ff @(posedge mclk) begin
    if (rst) begin
      s_r <= '{st: CLRS_FRAME_PREP, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // pulse generators
  // ----------------------------------------------------------------
  // sense only after second pixel of pair
  assign sense_en = ~s_r.bin | s_r.pcnt[0];
  assign hrun     = (s_r.st == CLRS_HREAD);
  assign vact     = (s_r.st == CLRS_VSHIFT);

  clrs_vclock_gen u_vgen (
    .mclk   (mclk),
    .rst    (rst),
    .vcount (s_r.vcnt),
    .active (vact),
    .v1_clk (v1_clk),
    .v2_clk (v2_clk)
  );

  clrs_phase_gen u_hgen (
    .mclk                  (mclk),
    .rst                   (rst),
    .run                   (hrun),
    .phase                 (s_r.phase),
    .sense_en              (sense_en),
    .h1_clk                (h1_clk),
    .h2_clk                (h2_clk),
    .diffusion_reset_clock (diffusion_reset_clock),
    .cds_clamp_pulse       (cds_clamp_pulse),
    .cds_sample_pulse      (cds_sample_pulse),
    .grabber_pixel_strobe  (grabber_pixel_strobe)
  );

  assign grabber_frame_sync = s_r.fsync;
  assign grabber_line_sync  = s_r.lsync;
  assign frame_done         = s_r.done;
  assign in_frame_prep      = (s_r.st == CLRS_FRAME_PREP);

endmodule
`default_nettype wire

/* verif/clrs_line_readout_props.sv */
// checker of the line readout sequencer port timing
`timescale 1ns/100ps
`default_nettype none
module clrs_line_readout_props (
  input wire logic mclk,
  input wire logic rst,
  input wire logic binning_select_jumper,
  input wire logic frame_go,
  input wire logic v1_clk,
  input wire logic v2_clk,
  input wire logic h1_clk,
  input wire logic h2_clk,
  input wire logic diffusion_reset_clock,
  input wire logic cds_clamp_pulse,
  input wire logic cds_sample_pulse,
  input wire logic grabber_pixel_strobe,
  input wire logic grabber_frame_sync,
  input wire logic grabber_line_sync,
  input wire logic frame_done,
  input wire logic in_frame_prep
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // ----------------------------------------------------------------
  // pulse shapes and order
  // ----------------------------------------------------------------
  chk_strobe_width:
    assert property ($rose(grabber_pixel_strobe) |=> !grabber_pixel_strobe)
    else $error("pixel strobe not one clock");
  chk_reset_width:
    assert property ($rose(diffusion_reset_clock) |=> diffusion_reset_clock ##1 !diffusion_reset_clock)
    else $error("diffusion reset not two clocks");
  chk_clamp_sample:
    assert property ($rose(cds_clamp_pulse) |-> ##7 $rose(cds_sample_pulse))
    else $error("sample not seven clocks after clamp");
  chk_sample_strobe:
    assert property ($rose(cds_sample_pulse) |-> ##3 $rose(grabber_pixel_strobe))
    else $error("strobe not three clocks after sample");
  chk_h_phases:
    assert property (!(h1_clk && h2_clk))
    else $error("horizontal phases overlap");
  chk_h_complement:
    assert property (grabber_line_sync |-> h2_clk == !h1_clk)
    else $error("horizontal phases not complementary in readout");
  chk_strobe_sensed:
    assert property ($rose(grabber_pixel_strobe) |->
      $past(cds_sample_pulse, 2) && $past(cds_clamp_pulse, 9) && $past(diffusion_reset_clock, 12))
    else $error("pixel strobe without reset clamp and sample");
  chk_v_overlap:
    assert property (($rose(v2_clk) |-> v1_clk) and ($fell(v1_clk) |-> v2_clk))
    else $error("vertical phases out of order");
  chk_v_quiet_read:
    assert property (grabber_line_sync |-> !v1_clk && !v2_clk)
    else $error("vertical clock during readout");
  chk_line_in_frame:
    assert property (grabber_line_sync |-> grabber_frame_sync)
    else $error("line sync outside frame");
  chk_done_prep:
    assert property (frame_done |=> in_frame_prep && !frame_done)
    else $error("no return to frame prep");
  chk_reset_state:
    assert property (disable iff (1'b0) rst |=> in_frame_prep && !v1_clk && !grabber_frame_sync)
    else $error("reset state wrong");
endmodule
bind clrs_line_readout clrs_line_readout_props chk_u (.mclk(mclk), .rst(rst),
  .binning_select_jumper(binning_select_jumper), .frame_go(frame_go), .v1_clk(v1_clk),
  .v2_clk(v2_clk), .h1_clk(h1_clk), .h2_clk(h2_clk),
  .diffusion_reset_clock(diffusion_reset_clock), .cds_clamp_pulse(cds_clamp_pulse),
  .cds_sample_pulse(cds_sample_pulse), .grabber_pixel_strobe(grabber_pixel_strobe),
  .grabber_frame_sync(grabber_frame_sync), .grabber_line_sync(grabber_line_sync),
  .frame_done(frame_done), .in_frame_prep(in_frame_prep));
`default_nettype wire

/* verif/clrs_far_model.sv */
// far side model: sensor clock receivers and grabber edge counters
`timescale 1ns/100ps
`default_nettype none
module clrs_far_model (
  input  wire logic mclk,
  input  wire logic clr,
  input  wire logic v1_clk,
  input  wire logic h1_clk,
  input  wire logic grabber_pixel_strobe,
  input  wire logic grabber_line_sync,
  output var  int   n_pix,
  output var  int   n_line,
  output var  int   n_v1,
  output var  int   n_h1,
  output var  int   min_gap
);
  logic v1_q, h1_q, pix_q, ln_q;
  int   gap;
  // count rising edges as the sensor and grabber see them
  always @(posedge mclk) begin
    {v1_q, h1_q, pix_q, ln_q} <= {v1_clk, h1_clk, grabber_pixel_strobe, grabber_line_sync};
    gap <= gap + 1;
    if (clr) begin
      {n_pix, n_line, n_v1, n_h1, gap} <= '0;
      min_gap <= 9999;
    end else begin
      if (v1_clk && !v1_q) n_v1 <= n_v1 + 1;
      if (h1_clk && !h1_q) n_h1 <= n_h1 + 1;
      if (grabber_line_sync && !ln_q) n_line <= n_line + 1;
      if (grabber_pixel_strobe && !pix_q) begin
        n_pix <= n_pix + 1;
        gap <= 1;
        if (n_pix > 0 && gap < min_gap) min_gap <= gap;
      end
    end
  end
endmodule
`default_nettype wire

/* verif/tb.sv */
// testbench of the line readout sequencer
`timescale 1ns/100ps
`default_nettype none
module tb;
  import clrs_pkg::*;
  logic mclk = 0, rst = 1, binning_select_jumper = 0, frame_go = 0, clr = 1;
  logic v1_clk, v2_clk, h1_clk, h2_clk, diffusion_reset_clock, cds_clamp_pulse;
  logic cds_sample_pulse, grabber_pixel_strobe, grabber_frame_sync, grabber_line_sync;
  logic frame_done, in_frame_prep;
  int   n_pix, n_line, n_v1, n_h1, min_gap, n_fail = 0, samples_checked = 0, k;
  // 200 MHz clock
  always #2.5 mclk = ~mclk;
  clrs_line_readout dut_u (.mclk(mclk), .rst(rst), .binning_select_jumper(binning_select_jumper),
    .frame_go(frame_go), .v1_clk(v1_clk), .v2_clk(v2_clk), .h1_clk(h1_clk), .h2_clk(h2_clk),
    .diffusion_reset_clock(diffusion_reset_clock), .cds_clamp_pulse(cds_clamp_pulse),
    .cds_sample_pulse(cds_sample_pulse), .grabber_pixel_strobe(grabber_pixel_strobe),
    .grabber_frame_sync(grabber_frame_sync), .grabber_line_sync(grabber_line_sync),
    .frame_done(frame_done), .in_frame_prep(in_frame_prep));
  clrs_far_model far_u (.mclk(mclk), .clr(clr), .v1_clk(v1_clk), .h1_clk(h1_clk),
    .grabber_pixel_strobe(grabber_pixel_strobe), .grabber_line_sync(grabber_line_sync),
    .n_pix(n_pix), .n_line(n_line), .n_v1(n_v1), .n_h1(n_h1), .min_gap(min_gap));
  // ----------------------------------------------------------------
  // compare and report
  // ----------------------------------------------------------------
  task automatic chk_bit(input string nm, input logic e, input logic g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic chk_int(input string nm, input integer e, input integer g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // expected pixel strobes in one frame
  function automatic int exp_pix(input logic b);
    return b ? (PIX_PER_ROW / 2) * (ROWS_PER_FRAME / 2) : PIX_PER_ROW * ROWS_PER_FRAME;
  endfunction
  // one whole frame, optionally flipping the jumper mid-frame
  task automatic run_frame(input logic b, input logic poke);
    int t;
    @(posedge mclk);
    clr <= 1;
    binning_select_jumper <= b;
    frame_go <= 1;
    @(posedge mclk);
    clr <= 0;
    t = 0;
    while (in_frame_prep !== 1'b0 && t < 50) begin
      @(negedge mclk);
      t++;
    end
    chk_bit("frame_started", 1'b0, in_frame_prep);
    chk_bit("frame_sync_start", 1'b1, grabber_frame_sync);
    @(posedge mclk);
    frame_go <= 0;
    if (poke) binning_select_jumper <= ~b;
    t = 0;
    while (frame_done !== 1'b1 && t < 4000) begin
      @(negedge mclk);
      t++;
    end
    chk_bit("frame_done_seen", 1'b1, frame_done);
    @(negedge mclk);
    chk_bit("prep_after_done", 1'b1, in_frame_prep);
    chk_bit("frame_sync_end", 1'b0, grabber_frame_sync);
    chk_int("pixel_strobes", exp_pix(b), n_pix);
    chk_int("line_syncs", b ? ROWS_PER_FRAME / 2 : ROWS_PER_FRAME, n_line);
    chk_int("row_shifts", ROWS_PER_FRAME, n_v1);
    chk_int("h_shifts", PIX_PER_ROW * (b ? ROWS_PER_FRAME / 2 : ROWS_PER_FRAME), n_h1);
    chk_int("strobe_gap", b ? 2 * PHASES : PHASES, min_gap);
    $display("test frame binning %0d poke %0d done", b, poke);
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    k = $urandom(24077);
    repeat (8) @(posedge mclk);
    rst <= 0;
    run_frame(1'b0, 1'b0);
    run_frame(1'b1, 1'b1);
    for (k = 0; k < 5; k++) run_frame(1'($urandom % 2), 1'($urandom % 2));
    @(posedge mclk);
    binning_select_jumper <= 1;
    frame_go <= 1;
    repeat (400) @(posedge mclk);
    frame_go <= 0;
    rst <= 1;
    repeat (2) @(posedge mclk);
    rst <= 0;
    @(negedge mclk);
    chk_bit("prep_on_reset", 1'b1, in_frame_prep);
    chk_bit("frame_sync_on_reset", 1'b0, grabber_frame_sync);
    $display("test mid-frame reset done");
    run_frame(1'b0, 1'b0);
    print_verdict();
  end
  // hang guard: eight frames and the mid-frame reset test take well under this
  initial begin
    repeat (40000) @(posedge mclk);
    n_fail++;
    print_verdict();
  end
endmodule
`default_nettype wire
